// File: qenc_chan_if.sv
// signals between the register shell and one encoder channel
`timescale 1ns/1ps
`default_nettype none
interface qenc_chan_if;
	logic        [1:0] mode;      // latch trigger
	logic              pol_fall;  // fast input falling edge
	logic              enable;    // channel counts
	logic       [23:0] count;     // position
	logic       [23:0] latch;     // captured position
	logic              cap_pulse; // capture happened
	modport shell (output mode, pol_fall, enable, input count, latch, cap_pulse);
	modport chan (input mode, pol_fall, enable, output count, latch, cap_pulse);
endinterface
`default_nettype wire

// File: qenc_channel.sv
// one quadrature channel: filter, decode, counter and latch
//
// Not in this module: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "qenc_map.svh"
module qenc_channel
	import qenc_pkg::*;
#(
	parameter int FILT = `QENC_FAST_FILT_CYC
) (
	input  wire logic i_mclk,
	input  wire logic i_sys_rst,
	input  wire logic i_ce,
	input  wire logic i_a,
	input  wire logic i_b,
	input  wire logic i_index,
	input  wire logic i_fast,
	qenc_chan_if.chan ch
);
	// ==========================================================
	// state
	typedef struct packed {
		logic [1:0]  ab_q;
		logic        idx_q;
		logic        fast_raw;
		logic        fast_q;
		logic [3:0]  fcnt;
		logic [23:0] count;
		logic [23:0] latch;
		arm_state_t  arm;
		logic        cap;
	} st_t;
	st_t s;
	st_t next_s;
	logic up;
	logic dn;
	logic fast_edge;
	logic idx_rise;
	// ==========================================================
	// next state
	always_comb begin
		next_s = s;
		next_s.cap = 1'b0;
		next_s.ab_q = {i_a, i_b};
		next_s.idx_q = i_index;
		// light fast filter: short stable count
		if (i_fast != s.fast_raw) begin
			next_s.fast_raw = i_fast;
			next_s.fcnt = 4'h0;
		end else if (s.fcnt < 4'(FILT)) begin
			next_s.fcnt = s.fcnt + 4'h1;
		end else begin
			next_s.fast_q = s.fast_raw;
		end
		// a leads b counts up, lags counts down
		up = (s.ab_q[1] ^ s.ab_q[0]) ? (i_a == s.ab_q[1]) : (i_b == s.ab_q[0]);
		up = up && ({i_a, i_b} != s.ab_q) && ({i_a, i_b} != ~s.ab_q);
		dn = ({i_a, i_b} != s.ab_q) && ({i_a, i_b} != ~s.ab_q) && !up;
		if (ch.enable && up) begin
			next_s.count = s.count + 24'h000001;
		end else if (ch.enable && dn) begin
			next_s.count = s.count - 24'h000001;
		end
		idx_rise = i_index && !s.idx_q;
		fast_edge = (next_s.fast_q != s.fast_q) && (next_s.fast_q == !ch.pol_fall);
		case (latch_mode_t'(ch.mode))
			LATCH_INDEX: begin
				if (idx_rise) begin
					next_s.cap = 1'b1;
				end
			end
			LATCH_FAST: begin
				if (fast_edge) begin
					next_s.cap = 1'b1;
				end
			end
			LATCH_ARMED_INDEX: begin
				if (s.arm == ARM_WAIT_INDEX && idx_rise) begin
					next_s.cap = 1'b1;
					next_s.arm = ARM_IDLE;
				end else if (fast_edge) begin
					next_s.arm = ARM_WAIT_INDEX;
				end
			end
			default: begin
				next_s.arm = ARM_IDLE;
			end
		endcase
		if (latch_mode_t'(ch.mode) != LATCH_ARMED_INDEX) begin
			next_s.arm = ARM_IDLE;
		end
		if (next_s.cap) begin
			next_s.latch = s.count;
		end
	end
	// ==========================================================
	// register
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			s <= '0;
		end else if (i_ce) begin
			s <= next_s;
		end
	end
	assign ch.count = s.count;
	assign ch.latch = s.latch;
	assign ch.cap_pulse = s.cap;
	// ==========================================================
	// checks
	property p_up_step;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(i_ce && ch.enable && s.ab_q == 2'b00 && {i_a, i_b} == 2'b10) |=>
		(s.count == $past(s.count) + 24'h000001);
	endproperty
	a_up_step: assert property (p_up_step) else $error("a-lead step wrong");
	property p_dn_step;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(i_ce && ch.enable && s.ab_q == 2'b00 && {i_a, i_b} == 2'b01) |=>
		(s.count == $past(s.count) - 24'h000001);
	endproperty
	a_dn_step: assert property (p_dn_step) else $error("a-lag step wrong");
	property p_hold;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(i_ce && {i_a, i_b} == s.ab_q) |=> (s.count == $past(s.count));
	endproperty
	a_hold: assert property (p_hold) else $error("count moved without edge");
	property p_latch_hold;
		@(posedge i_mclk) disable iff (i_sys_rst)
		!next_s.cap |=> $stable(s.latch);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latch changed");
	property p_idx_cap;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(i_ce && ch.mode == 2'(LATCH_INDEX) && i_index && !s.idx_q) |=>
		(s.cap && s.latch == $past(s.count));
	endproperty
	a_idx_cap: assert property (p_idx_cap) else $error("index capture missed");
	property p_fast_cap;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(i_ce && ch.mode == 2'(LATCH_FAST) && fast_edge) |=> s.cap;
	endproperty
	a_fast_cap: assert property (p_fast_cap) else $error("fast capture missed");
	property p_fast_lat;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(i_ce && i_fast != s.fast_q) [*8] |-> ##[0:8] (s.fast_q == i_fast || !i_ce);
	endproperty
	a_fast_lat: assert property (p_fast_lat) else $error("fast filter slow");
	property p_arm;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(s.cap && $past(i_ce) && $past(ch.mode) == 2'(LATCH_ARMED_INDEX)) |->
		$past(s.arm == ARM_WAIT_INDEX);
	endproperty
	a_arm: assert property (p_arm) else $error("armed capture unarmed");
	c_idx: cover property (@(posedge i_mclk) s.cap && ch.mode == 2'(LATCH_INDEX));
	c_fast: cover property (@(posedge i_mclk) s.cap && ch.mode == 2'(LATCH_FAST));
	c_armed: cover property (@(posedge i_mclk) s.cap && ch.mode == 2'(LATCH_ARMED_INDEX));
	c_wrap: cover property (@(posedge i_mclk) s.count == 24'hFFFFFF ##1 s.count == 24'h000000);
endmodule // qenc_channel
`default_nettype wire

// File: qenc_enc_model.sv
// encoder and fast-input sensor model for all five channels
`timescale 1ns/1ps
`default_nettype none
module qenc_enc_model #(
	parameter int GAP = 125 // cycles waited after each edge: one edge per GAP + 1 = 126 cycles at 125 mhz
) (
	input  wire logic       i_mclk,
	output wire logic [4:0] o_a,
	output wire logic [4:0] o_b,
	output logic      [4:0] o_index,
	output logic      [4:0] o_fast
);
	logic [1:0] ph = 2'h0; // gray phase of a/b
	logic [4:0] a_p = 5'h00; // true wire of a
	logic [4:0] a_n = 5'h1F; // complement wire of a
	logic [4:0] b_p = 5'h00; // true wire of b
	logic [4:0] b_n = 5'h1F; // complement wire of b
	// line receiver: true high and complement low reads as one
	assign o_a = a_p & ~a_n;
	assign o_b = b_p & ~b_n;
	initial begin
		o_index = 5'h00;
		o_fast = 5'h00;
	end
	// ==========
	// quarter-period steps, a leads b when going up
	task automatic step(input logic up, input int n);
		repeat (n) begin
			ph = up ? ph + 2'h1 : ph - 2'h1;
			@(posedge i_mclk);
			a_p <= {5{ph[1] ^ ph[0]}};
			a_n <= ~{5{ph[1] ^ ph[0]}};
			b_p <= {5{ph[1]}};
			b_n <= ~{5{ph[1]}};
			repeat (GAP) @(posedge i_mclk);
		end
	endtask
	// index pulse on every channel
	task automatic pulse();
		@(posedge i_mclk);
		o_index <= 5'h1F;
		repeat (4) @(posedge i_mclk);
		o_index <= 5'h00;
		repeat (8) @(posedge i_mclk);
	endtask
	// new fast-input level, then time for the filter
	task automatic fast(input logic [4:0] v);
		@(posedge i_mclk);
		o_fast <= v;
		repeat (12) @(posedge i_mclk);
	endtask
endmodule // qenc_enc_model
`default_nettype wire

// File: qenc_map.svh
// offsets, field positions, reset values and timing counts of the encoder block
`ifndef QENC_MAP_SVH
`define QENC_MAP_SVH
// ==========================================================
// register word offsets (byte address = offset)
`define QENC_OFF_CTRL     8'h00
`define QENC_OFF_STATUS   8'h04
`define QENC_OFF_MASK     8'h08
`define QENC_OFF_COUNT0   8'h20
`define QENC_OFF_LATCH0   8'h40
// ==========================================================
// ctrl fields per channel, 4 bits each
`define QENC_CTRL_W       4
`define QENC_CTRL_MODE_LO 0
`define QENC_CTRL_POL     2
`define QENC_CTRL_EN      3
// ==========================================================
// reset values
`define QENC_CTRL_RST     32'h0000_0000
`define QENC_MASK_RST     8'h00
// ==========================================================
// timing: fastest line rate, counts per second and fast input filter
`define QENC_LINE_RATE_HZ 250000
`define QENC_COUNT_RATE_HZ 1000000
`define QENC_CLK_HZ       125000000
`define QENC_FAST_FILT_NS 16
`define QENC_FAST_FILT_CYC ((`QENC_FAST_FILT_NS * 125 + 999) / 1000)
`define QENC_DC_FILT_CYC  64
`endif

// File: qenc_pkg.sv
// types shared by the encoder block
package qenc_pkg;
	// latch trigger selection
	typedef enum logic [1:0] {
		LATCH_INDEX,
		LATCH_FAST,
		LATCH_ARMED_INDEX,
		LATCH_OFF
	} latch_mode_t;
	// armed-index progress
	typedef enum logic {
		ARM_IDLE,
		ARM_WAIT_INDEX
	} arm_state_t;
endpackage

// File: qenc_top.sv
// five-channel quadrature counter with latches behind an avalon-mm slave
//
// Function
// - a leading b counts upward
// - a lagging b counts downward
// - count up to 250k lines, 1M counts/s
// - one 24-bit up/down counter per channel
// - step on every a and b edge
// - five 24-bit latches, each with fast input
// - index mode latches count on index
// - fast mode latches on chosen fast edge
// - armed mode latches first index after edge
// - fast capture in hardware, no scan wait
// - fast input lightly filtered for speed
`timescale 1ns/1ps
`default_nettype none
`include "qenc_map.svh"
module qenc_top
	import qenc_pkg::*;
#(
	parameter int NCH  = 5,
	parameter int FILT = `QENC_FAST_FILT_CYC
) (
	input  wire logic        i_mclk,        // 125 mhz
	input  wire logic        i_sys_rst,     // sync, high
	input  wire logic        i_ce,          // clock enable
	input  wire logic [4:0]  i_enc_a,       // a, after receivers
	input  wire logic [4:0]  i_enc_b,       // b, after receivers
	input  wire logic [4:0]  i_enc_index,   // index
	input  wire logic [4:0]  i_fast,        // isolated fast inputs
	input  wire logic [7:0]  i_address,     // byte address
	input  wire logic        i_read,
	input  wire logic        i_write,
	input  wire logic [31:0] i_writedata,
	input  wire logic [3:0]  i_byteenable,
	output logic      [31:0] o_readdata,
	output logic             o_waitrequest,
	output logic             o_irq          // level interrupt
);
	// ==========================================================
	// state
	typedef struct packed {
		logic [31:0] ctrl;   // 4 bits per channel
		logic [7:0]  status; // sticky capture flags
		logic [7:0]  mask;   // interrupt enables
		logic [31:0] rdata;
		logic        ack;
	} st_t;
	st_t s;
	st_t next_s;
	logic [4:0]  cap;
	logic [23:0] cnt [5];
	logic [23:0] lat [5];
	// ==========================================================
	// merge byte lanes into a word
	function automatic logic [31:0] be_merge(input logic [31:0] old,
			input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int k = 0; k < 4; k++) begin
			if (be[k]) begin
				r[k*8 +: 8] = wd[k*8 +: 8];
			end
		end
		return r;
	endfunction
	// ==========================================================
	// channels
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : gch
			qenc_chan_if cif ();
			assign cif.mode = s.ctrl[g*`QENC_CTRL_W + `QENC_CTRL_MODE_LO +: 2];
			assign cif.pol_fall = s.ctrl[g*`QENC_CTRL_W + `QENC_CTRL_POL];
			assign cif.enable = s.ctrl[g*`QENC_CTRL_W + `QENC_CTRL_EN];
			assign cap[g] = cif.cap_pulse;
			assign cnt[g] = cif.count;
			assign lat[g] = cif.latch;
			qenc_channel #(.FILT(FILT)) u_ch (
				.i_mclk    (i_mclk),
				.i_sys_rst (i_sys_rst),
				.i_ce      (i_ce),
				.i_a       (i_enc_a[g]),
				.i_b       (i_enc_b[g]),
				.i_index   (i_enc_index[g]),
				.i_fast    (i_fast[g]),
				.ch        (cif.chan)
			);
		end
	endgenerate
	// ==========================================================
	// bus and flags
	always_comb begin
		next_s = s;
		next_s.ack = 1'b0;
		next_s.status = s.status;
		if ((i_read || i_write) && !s.ack) begin
			next_s.ack = 1'b1;
			next_s.rdata = 32'h0000_0000;
			if (i_read) begin
				if (i_address == `QENC_OFF_CTRL) begin
					next_s.rdata = s.ctrl;
				end else if (i_address == `QENC_OFF_STATUS) begin
					next_s.rdata = {24'h000000, s.status};
				end else if (i_address == `QENC_OFF_MASK) begin
					next_s.rdata = {24'h000000, s.mask};
				end else begin
					for (int k = 0; k < 5; k++) begin
						if (i_address == `QENC_OFF_COUNT0 + 8'(4*k)) begin
							next_s.rdata = {8'h00, cnt[k]};
						end
						if (i_address == `QENC_OFF_LATCH0 + 8'(4*k)) begin
							next_s.rdata = {8'h00, lat[k]};
						end
					end
				end
			end else begin
				if (i_address == `QENC_OFF_CTRL) begin
					next_s.ctrl = be_merge(s.ctrl, i_writedata, i_byteenable) & 32'h000F_FFFF;
				end else if (i_address == `QENC_OFF_STATUS && i_byteenable[0]) begin
					next_s.status = s.status & ~i_writedata[7:0];
				end else if (i_address == `QENC_OFF_MASK && i_byteenable[0]) begin
					next_s.mask = i_writedata[7:0] & 8'h1F;
				end
			end
		end
		// set wins over write-one clear
		next_s.status = next_s.status | {3'b000, cap};
	end
	// ==========================================================
	// register, frozen while ce low
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			s <= '0;
		end else if (i_ce) begin
			s <= next_s;
		end
	end
	assign o_readdata = s.rdata;
	// a held ack only answers while the clock enable lets the bus state move on
	assign o_waitrequest = (i_read || i_write) && !(s.ack && i_ce);
	assign o_irq = |(s.status & s.mask);
	// ==========================================================
	// checks
	property p_irq;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(i_ce && cap[0]) |=> (o_irq || !s.mask[0]);
	endproperty
	a_irq: assert property (p_irq) else $error("irq not raised");
	property p_sticky;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(i_ce && cap[0]) |=> s.status[0];
	endproperty
	a_sticky: assert property (p_sticky) else $error("capture flag lost");
	c_irq: cover property (@(posedge i_mclk) o_irq);
endmodule // qenc_top
`default_nettype wire

// File: qenc_top_test.sv
// self-checking bench for the five-channel encoder counter
`timescale 1ns/1ps
`default_nettype none
`include "qenc_map.svh"
module qenc_top_test;
	typedef struct {logic [7:0] adr; logic [31:0] val;} note_t;
	localparam logic [7:0] CT = `QENC_OFF_CTRL;
	localparam logic [7:0] ST = `QENC_OFF_STATUS;
	localparam logic [7:0] MK = `QENC_OFF_MASK;
	localparam logic [7:0] CN = `QENC_OFF_COUNT0;
	localparam logic [7:0] LT = `QENC_OFF_LATCH0;
	logic        i_mclk = 1'b0;
	logic        i_sys_rst = 1'b1;
	logic        i_ce = 1'b1;
	logic [3:0]  i_byteenable = 4'hF;
	logic [7:0]  i_address = 8'h00;
	logic        i_read = 1'b0;
	logic        i_write = 1'b0;
	logic [31:0] i_writedata = 32'h0;
	logic [31:0] o_readdata;
	logic        o_waitrequest;
	logic        o_irq;
	wire  [4:0]  a, b, idx, fst; // encoder side
	note_t       q[$]; // expected reads, oldest first
	note_t       nt;
	int          fail_count = 0, checked = 0, cyc = 0, seed = 12809, n;
	logic [23:0] c1, c2; // expected counts
	always #4 i_mclk = ~i_mclk;
	qenc_enc_model enc_u (.i_mclk(i_mclk), .o_a(a), .o_b(b), .o_index(idx), .o_fast(fst));
	qenc_top dut_u (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_enc_a(a),
		.i_enc_b(b), .i_enc_index(idx), .i_fast(fst), .i_address(i_address),
		.i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
		.i_byteenable(i_byteenable), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
		.o_irq(o_irq));
	// ==========
	// avalon cycle: hold until waitrequest low
	task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] d);
		@(posedge i_mclk);
		i_read <= ~wr;
		i_write <= wr;
		i_address <= adr;
		i_writedata <= d;
		@(posedge i_mclk);
		while (o_waitrequest !== 1'b0) begin
			@(posedge i_mclk);
		end
		i_read <= 1'b0;
		i_write <= 1'b0;
	endtask
	// read with the expected word noted
	task automatic rd(input logic [7:0] adr, input logic [31:0] v);
		q.push_back('{adr, v});
		bus(1'b0, adr, 32'h0);
	endtask
	// one word per channel, odd channels may differ
	task automatic rd_all(input logic [7:0] base, input logic [23:0] ev, input logic [23:0] od);
		for (int i = 0; i < 5; i++)
			rd(base + 8'(4 * i), {8'h00, i[0] ? od : ev});
	endtask
	// interrupt level once the write has landed
	task automatic chk(input logic exp);
		repeat (2) @(posedge i_mclk);
		checked++;
		if (o_irq !== exp) begin
			fail_count++;
			$display("MISMATCH o_irq exp %b got %b", exp, o_irq);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ==========
	// read monitor and hang limit
	always @(posedge i_mclk) begin
		cyc++;
		if (i_read && o_waitrequest === 1'b0) begin
			nt = q.pop_front();
			checked++;
			if (o_readdata !== nt.val) begin
				fail_count++;
				$display("MISMATCH rd %h exp %h got %h", nt.adr, nt.val, o_readdata);
			end
		end
		if (cyc == 20000) begin
			fail_count++;
			wrap_up();
		end
	end
	// ==========
	// main sequence
	initial begin
		n = ($random(seed) & 7) + 1;
		repeat (16) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
		rd(CT, `QENC_CTRL_RST);
		rd(MK, 32'h0);
		bus(1'b1, 8'hFC, 32'hFFFFFFFF);
		rd(8'hFC, 32'h0);
		enc_u.step(1'b1, 4);
		rd_all(CN, 24'h0, 24'h0);
		bus(1'b1, CT, 32'h00088888);
		enc_u.step(1'b1, n);
		c1 = 24'(n);
		rd_all(CN, c1, c1);
		enc_u.step(1'b0, n + 3);
		c1 = c1 - 24'(n + 3);
		rd_all(CN, c1, c1);
		// clock enable low for a random spell: read waits, count frozen
		fork
			rd(CN, {8'h00, c1});
			begin
				i_ce <= 1'b0;
				repeat (n) @(posedge i_mclk);
				i_ce <= 1'b1;
			end
		join
		enc_u.pulse();
		rd_all(LT, c1, c1);
		rd(ST, 32'h1F);
		chk(1'b0);
		bus(1'b1, MK, 32'h1F);
		chk(1'b1);
		bus(1'b1, ST, 32'h1F);
		chk(1'b0);
		// fast mode: even channels rising, odd falling
		bus(1'b1, CT, 32'h0009D9D9);
		enc_u.fast(5'h1F);
		enc_u.step(1'b1, 2);
		c2 = c1 + 24'h2;
		enc_u.fast(5'h00);
		enc_u.pulse();
		rd_all(LT, c1, c2);
		// armed index: index alone does nothing
		bus(1'b1, CT, 32'h000AAAAA);
		enc_u.pulse();
		rd_all(LT, c1, c2);
		enc_u.fast(5'h1F);
		enc_u.step(1'b1, 1);
		c2 = c2 + 24'h1;
		enc_u.pulse();
		rd_all(LT, c2, c2);
		// trigger off: no capture at all
		bus(1'b1, CT, 32'h000BBBBB);
		// one byte lane only: ctrl keeps the other lanes
		i_byteenable <= 4'h2;
		bus(1'b1, CT, 32'hFFFFFFFF);
		i_byteenable <= 4'hF;
		rd(CT, 32'h000BFFBB);
		bus(1'b1, ST, 32'h1F);
		enc_u.fast(5'h00);
		enc_u.fast(5'h1F);
		enc_u.pulse();
		rd(ST, 32'h0);
		chk(1'b0);
		wrap_up();
	end
endmodule // qenc_top_test
`default_nettype wire
